// file: core/wwd_pkg.sv
// package for the windowed watchdog: offsets, fields, resets, timing
package wwd_pkg;
  // register byte offsets
  localparam logic [3:0]  CMD_OFS        = 4'h0;
  localparam logic [3:0]  CFG_OFS        = 4'h4;
  localparam logic [3:0]  FLAGS_OFS      = 4'h8;
  // command fields
  localparam int          KEY_LSB        = 24;
  localparam logic [7:0]  CMD_KEY        = 8'ha5;
  localparam int          RESTART_BIT    = 0;
  // config fields
  localparam int          LOAD_LSB       = 0;
  localparam int          FIEN_BIT       = 12;
  localparam int          RSTEN_BIT      = 13;
  localparam int          CORE_ONLY_BIT  = 14;
  localparam int          DIS_BIT        = 15;
  localparam int          DELTA_LSB      = 16;
  localparam int          DBG_HALT_BIT   = 28;
  localparam int          IDLE_HALT_BIT  = 29;
  localparam int          CNT_W          = 12;
  localparam logic [31:0] CFG_RESET      = 32'h3fff2fff;
  localparam logic [31:0] CFG_WMASK      = 32'h3fffffff;
  // flag bits
  localparam int          UNF_BIT        = 0;
  localparam int          ERR_BIT        = 1;
  // slow tick prescaler
  localparam int          PRESCALE       = 128;
  localparam int          PRE_W          = 7;
  // axi responses
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage : wwd_pkg

// file: core/wwd_top.sv
// windowed watchdog with axi4-lite register slave
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
// Behaviour
// [RL1] 12-bit down counter, tick is slow/128
// [RL2] processor reset: load 0xFFF, timer running
// [RL3] fault reset enable reads one after reset
// [RL4] config writable once until processor reset
// [RL5] config write reloads and restarts counter
// [RL6] keyed restart reloads counter and prescaler
// [RL7] command key must be 0xA5, else ignored
// [RL8] underflow sets flag, fault if enabled
// [RL9] restart allowed when count at most delta
// [RL10] early restart: error flag and fault
// [RL11] delta at least load: no window errors
// [RL12] interrupt enable gates flags to interrupt
// [RL13] scope bit selects core or full reset
// [RL14] fault reset clears block and flags
// [RL15] status read clears flags, irq, fault
// [RL16] status bit0 underflow, bit1 error, sticky
// [RL17] halt in debug or idle when enabled
// [RL18] disable bit stops the timer
// [RL19] config field layout fixed
// [RL20] disabled: no underflow, errors still checked
module wwd_top
  import wwd_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  // clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              rst_n_in,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] s_awaddr_in,
  input  wire logic              s_awvalid_in,
  output logic                   s_awready_out,
  input  wire logic [31:0]       s_wdata_in,
  input  wire logic [3:0]        s_wstrb_in,
  input  wire logic              s_wvalid_in,
  output logic                   s_wready_out,
  output logic [1:0]             s_bresp_out,
  output logic                   s_bvalid_out,
  input  wire logic              s_bready_in,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] s_araddr_in,
  input  wire logic              s_arvalid_in,
  output logic                   s_arready_out,
  output logic [31:0]            s_rdata_out,
  output logic [1:0]             s_rresp_out,
  output logic                   s_rvalid_out,
  input  wire logic              s_rready_in,
  // system inputs
  input  wire logic              slow_clk_in,
  input  wire logic              core_debug_in,
  input  wire logic              sys_idle_in,
  // fault outputs
  output logic                   fault_irq_out,
  output logic                   wdt_fault_out,
  output logic                   core_reset_req_out,
  output logic                   full_reset_req_out
);

  // write channel state
  logic              aw_hold_r, aw_hold_nxt;
  logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic              w_hold_r, w_hold_nxt;
  logic [31:0]       w_data_r, w_data_nxt;
  logic [3:0]        w_strb_r, w_strb_nxt;
  logic              bvalid_r, bvalid_nxt;
  logic [1:0]        bresp_r, bresp_nxt;
  // read channel state
  logic              rvalid_r, rvalid_nxt;
  logic [31:0]       rdata_r, rdata_nxt;
  logic [1:0]        rresp_r, rresp_nxt;
  // readies registered so every bus output leaves a flop
  logic              awready_r, awready_nxt;
  logic              wready_r, wready_nxt;
  logic              arready_r, arready_nxt;
  // watchdog state
  logic [31:0]       cfg_r, cfg_nxt;
  logic              cfg_locked_r, cfg_locked_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  logic [PRE_W-1:0]  pre_r, pre_nxt;
  logic [1:0]        flags_r, flags_nxt;
  logic              fault_r, fault_nxt;
  logic              irq_r, irq_nxt;
  logic              core_req_r, core_req_nxt;
  logic              full_req_r, full_req_nxt;
  // synchronisers for off-domain inputs
  logic [1:0]        slow_sync_r;
  logic [1:0]        dbg_sync_r;
  logic [1:0]        idle_sync_r;
  logic              slow_prev_r;
  // decoded strobes
  logic              wr_fire;
  logic              rd_fire;
  logic              cmd_write;
  logic              cfg_write;
  logic              flags_read;
  logic              restart_ok;
  logic              restart_early;
  logic              tick;
  logic              halted;

  // byte-lane merge, used by the config write only
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // word decode of an address
  function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
    return a[3:0] == ofs;
  endfunction

  // level inputs pass two flops; slow clock gets a third for edge detect
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      slow_sync_r <= 2'h0;
      dbg_sync_r  <= 2'h0;
      idle_sync_r <= 2'h0;
      slow_prev_r <= 1'b0;
    end else begin
      slow_sync_r <= {slow_sync_r[0], slow_clk_in};
      dbg_sync_r  <= {dbg_sync_r[0], core_debug_in};
      idle_sync_r <= {idle_sync_r[0], sys_idle_in};
      slow_prev_r <= slow_sync_r[1];
    end
  end

  // rising edge of synchronised slow clock
  assign tick = slow_sync_r[1] & ~slow_prev_r;

  // access decode
  assign wr_fire       = aw_hold_r & w_hold_r & ~bvalid_r;
  assign rd_fire       = s_arvalid_in & ~rvalid_r;
  assign cmd_write     = wr_fire && is_reg(aw_addr_r, CMD_OFS) && w_strb_r[3]
                         && (w_data_r[KEY_LSB +: 8] == CMD_KEY) && w_data_r[RESTART_BIT]; // [RL7]
  assign cfg_write     = wr_fire && is_reg(aw_addr_r, CFG_OFS) && !cfg_locked_r;
  assign flags_read    = rd_fire && is_reg(s_araddr_in, FLAGS_OFS);
  // window check: count above delta is an early restart
  assign restart_ok    = cmd_write && (cnt_r <= cfg_r[DELTA_LSB +: CNT_W]); // [RL9] [RL11]
  assign restart_early = cmd_write && (cnt_r >  cfg_r[DELTA_LSB +: CNT_W]); // [RL10]
  assign halted        = cfg_r[DIS_BIT] // [RL18] [RL20]
                         || (cfg_r[DBG_HALT_BIT] && dbg_sync_r[1]) // [RL17]
                         || (cfg_r[IDLE_HALT_BIT] && idle_sync_r[1]);

  // axi write path: address and data taken in either order
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_hold_nxt  = w_hold_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (s_awvalid_in && !aw_hold_r) begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = s_awaddr_in;
    end
    if (s_wvalid_in && !w_hold_r) begin
      w_hold_nxt = 1'b1;
      w_data_nxt = s_wdata_in;
      w_strb_nxt = s_wstrb_in;
    end
    if (wr_fire) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      // mapped writes, locked-config and flags included, answer okay; unmapped answer slverr
      bresp_nxt   = (is_reg(aw_addr_r, CMD_OFS) || is_reg(aw_addr_r, CFG_OFS) || is_reg(aw_addr_r, FLAGS_OFS))
                    ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_r && s_bready_in) begin
      bvalid_nxt = 1'b0;
    end
    // ready drops in the same cycle a channel becomes held
    awready_nxt = ~aw_hold_nxt;
    wready_nxt  = ~w_hold_nxt;
  end

  // axi read path: one-cycle answer, held until taken
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rd_fire) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      if (is_reg(s_araddr_in, CFG_OFS)) begin
        rdata_nxt = cfg_r;
      end else if (is_reg(s_araddr_in, FLAGS_OFS)) begin
        rdata_nxt = {30'h0, flags_r}; // [RL16]
      end else begin
        rdata_nxt = 32'h0; // command is write-only, reads zero
        rresp_nxt = is_reg(s_araddr_in, CMD_OFS) ? RESP_OKAY : RESP_SLVERR;
      end
    end else if (rvalid_r && s_rready_in) begin
      rvalid_nxt = 1'b0;
    end
    arready_nxt = ~rvalid_nxt; // one read in flight at most
  end

  // watchdog core: config, counter, prescaler, flags, fault
  always_comb begin
    cfg_nxt        = cfg_r;
    cfg_locked_nxt = cfg_locked_r;
    cnt_nxt        = cnt_r;
    pre_nxt        = pre_r;
    flags_nxt      = flags_r;
    fault_nxt      = fault_r;
    if (cfg_write) begin
      cfg_nxt        = merge_lanes(cfg_r, w_data_r, w_strb_r) & CFG_WMASK; // [RL19]
      cfg_locked_nxt = 1'b1; // [RL4]
      cnt_nxt        = cfg_nxt[LOAD_LSB +: CNT_W]; // [RL5]
      pre_nxt        = '0;
    end else if (restart_ok) begin
      cnt_nxt = cfg_r[LOAD_LSB +: CNT_W]; // [RL6]
      pre_nxt = '0;
    end else if (!halted && tick) begin
      pre_nxt = pre_r + 1'b1; // [RL1]
      if (pre_r == PRE_W'(PRESCALE - 1)) begin
        if (cnt_r == '0) begin
          flags_nxt[UNF_BIT] = 1'b1; // [RL8]
          if (cfg_r[RSTEN_BIT]) begin
            fault_nxt = 1'b1;
          end
          cnt_nxt = cfg_r[LOAD_LSB +: CNT_W];
        end else begin
          cnt_nxt = cnt_r - 1'b1; // [RL1]
        end
      end
    end
    // status read clears; an event in the same cycle wins
    if (flags_read) begin
      flags_nxt = 2'h0; // [RL15]
      fault_nxt = 1'b0;
      if (!halted && tick && pre_r == PRE_W'(PRESCALE - 1) && cnt_r == '0 && !cfg_write && !restart_ok) begin
        flags_nxt[UNF_BIT] = 1'b1;
        fault_nxt          = cfg_r[RSTEN_BIT];
      end
    end
    if (restart_early) begin
      flags_nxt[ERR_BIT] = 1'b1; // [RL10]
      fault_nxt          = 1'b1;
    end
    irq_nxt      = cfg_r[FIEN_BIT] && (flags_nxt != 2'h0); // [RL12]
    core_req_nxt = fault_nxt && cfg_r[RSTEN_BIT] && cfg_r[CORE_ONLY_BIT]; // [RL13]
    full_req_nxt = fault_nxt && cfg_r[RSTEN_BIT] && !cfg_r[CORE_ONLY_BIT];
  end

  // registers; rst_n_in is the processor reset, also driven by our fault reset
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      aw_hold_r    <= 1'b0;
      aw_addr_r    <= '0;
      w_hold_r     <= 1'b0;
      w_data_r     <= 32'h0;
      w_strb_r     <= 4'h0;
      bvalid_r     <= 1'b0;
      bresp_r      <= RESP_OKAY;
      rvalid_r     <= 1'b0;
      rdata_r      <= 32'h0;
      rresp_r      <= RESP_OKAY;
      awready_r    <= 1'b1;
      wready_r     <= 1'b1;
      arready_r    <= 1'b1;
      cfg_r        <= CFG_RESET; // [RL2] [RL3] [RL11]
      cfg_locked_r <= 1'b0; // [RL4]
      cnt_r        <= CFG_RESET[LOAD_LSB +: CNT_W]; // [RL2]
      pre_r        <= '0;
      flags_r      <= 2'h0; // [RL14] [RL15]
      fault_r      <= 1'b0;
      irq_r        <= 1'b0;
      core_req_r   <= 1'b0;
      full_req_r   <= 1'b0;
    end else begin
      aw_hold_r    <= aw_hold_nxt;
      aw_addr_r    <= aw_addr_nxt;
      w_hold_r     <= w_hold_nxt;
      w_data_r     <= w_data_nxt;
      w_strb_r     <= w_strb_nxt;
      bvalid_r     <= bvalid_nxt;
      bresp_r      <= bresp_nxt;
      rvalid_r     <= rvalid_nxt;
      rdata_r      <= rdata_nxt;
      rresp_r      <= rresp_nxt;
      awready_r    <= awready_nxt;
      wready_r     <= wready_nxt;
      arready_r    <= arready_nxt;
      cfg_r        <= cfg_nxt;
      cfg_locked_r <= cfg_locked_nxt;
      cnt_r        <= cnt_nxt;
      pre_r        <= pre_nxt;
      flags_r      <= flags_nxt;
      fault_r      <= fault_nxt;
      irq_r        <= irq_nxt;
      core_req_r   <= core_req_nxt;
      full_req_r   <= full_req_nxt;
    end
  end

  // outputs straight from flops
  assign s_awready_out      = awready_r;
  assign s_wready_out       = wready_r;
  assign s_bvalid_out       = bvalid_r;
  assign s_bresp_out        = bresp_r;
  assign s_arready_out      = arready_r;
  assign s_rvalid_out       = rvalid_r;
  assign s_rdata_out        = rdata_r;
  assign s_rresp_out        = rresp_r;
  assign fault_irq_out      = irq_r;
  assign wdt_fault_out      = fault_r;
  assign core_reset_req_out = core_req_r;
  assign full_reset_req_out = full_req_r;

  // checks
  AST_KEY_GUARD: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RL7]
    (wr_fire && is_reg(aw_addr_r, CMD_OFS) && w_data_r[KEY_LSB +: 8] != CMD_KEY && !cfg_write)
      |=> $stable(cnt_r) || $past(tick))
    else $error("bad key changed the counter");
  AST_CFG_ONCE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RL4]
    cfg_locked_r |=> $stable(cfg_r))
    else $error("locked config changed");
  AST_CFG_RELOAD: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RL5]
    cfg_write |=> cnt_r == cfg_r[LOAD_LSB +: CNT_W] && pre_r == '0)
    else $error("config write did not reload");
  AST_RESTART: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RL6]
    restart_ok && !cfg_write |=> cnt_r == cfg_r[LOAD_LSB +: CNT_W] && pre_r == '0)
    else $error("restart did not reload");
  AST_EARLY_ERR: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RL10]
    restart_early |=> flags_r[ERR_BIT] && fault_r)
    else $error("early restart not flagged");
  AST_UNF: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RL8]
    (!halted && tick && pre_r == PRE_W'(PRESCALE - 1) && cnt_r == '0 && !cfg_write && !restart_ok
      && !restart_early)
      |=> flags_r[UNF_BIT] && (fault_r == $past(cfg_r[RSTEN_BIT])))
    else $error("underflow not flagged");
  AST_READ_CLR: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RL15]
    (flags_read && !restart_early && !(tick && cnt_r == '0)) |=> flags_r == 2'h0 && !fault_r)
    else $error("status read did not clear");
  AST_IRQ: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RL12]
    ##1 irq_r == ($past(cfg_r[FIEN_BIT]) && flags_r != 2'h0))
    else $error("interrupt does not follow flags");
  AST_HALT: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RL17] [RL18]
    (halted && !cfg_write && !restart_ok) |=> $stable(cnt_r))
    else $error("counter moved while halted");
  AST_SCOPE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RL13]
    !(core_reset_req_out && full_reset_req_out))
    else $error("both reset scopes requested");
  AST_FAULT_REQ: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RL8] [RL13]
    (fault_r && cfg_r[RSTEN_BIT] && $stable(cfg_r)) |-> (core_reset_req_out || full_reset_req_out))
    else $error("enabled fault raised no reset request");
  AST_UNF_STICKY: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RL16]
    (flags_r[UNF_BIT] && !flags_read) |=> flags_r[UNF_BIT])
    else $error("underflow flag dropped without a read");
  AST_ERR_STICKY: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RL16]
    (flags_r[ERR_BIT] && !flags_read) |=> flags_r[ERR_BIT])
    else $error("error flag dropped without a read");
  AST_DIS_NO_UNF: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // [RL20]
    (cfg_r[DIS_BIT] && !flags_read && !flags_r[UNF_BIT]) |=> !flags_r[UNF_BIT])
    else $error("underflow while disabled");

  COV_RESTART: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) restart_ok);
  COV_EARLY: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) restart_early);
  COV_UNF: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) $rose(flags_r[UNF_BIT]));
  COV_CFG: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) cfg_write);
  COV_HALT: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) halted && dbg_sync_r[1]);

endmodule : wwd_top

// file: tb/wwd_sys_model.sv
// reset controller and slow oscillator beside the watchdog
`timescale 1ns/1ps
module wwd_sys_model (
  // clock and fault requests
  input  wire logic sys_clk_in,
  input  wire logic core_req_in,
  input  wire logic full_req_in,
  // slow clock and processor reset
  output logic      slow_clk_out,
  output logic      rst_n_out
);
  logic div_r;
  int   hold_r;
  initial begin
    slow_clk_out = 1'b0;
    rst_n_out = 1'b1;
    div_r = 1'b0;
    hold_r = 0;
  end
  // slow clock at a quarter of the system rate, under the half-rate limit
  always @(posedge sys_clk_in) begin
    div_r <= ~div_r;
    if (div_r) slow_clk_out <= ~slow_clk_out;
  end
  // a request pulls reset low for three cycles after some latency
  always @(posedge sys_clk_in) begin
    if (hold_r != 0) hold_r <= hold_r - 1;
    else if (core_req_in || full_req_in) hold_r <= 8;
    rst_n_out <= !(hold_r >= 1 && hold_r <= 3);
  end
endmodule // wwd_sys_model

// file: tb/windowed_watchdog_timer_tb_top.sv
// self-checking bench for the windowed watchdog
`timescale 1ns/1ps
module windowed_watchdog_timer_tb_top;
  import wwd_pkg::*;
  logic        clk, rstb, crst, scl, dbg, idle, irq, fault, creq, freq;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, v, m_cfg;
  logic [1:0]  bresp, rresp, resp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, m_lock;
  int          error_cnt, checks, seed, n;

  wwd_top dut (
    .sys_clk_in(clk), .rst_n_in(rstb & crst),
    .s_awaddr_in(awaddr), .s_awvalid_in(awvalid), .s_awready_out(awready),
    .s_wdata_in(wdata), .s_wstrb_in(wstrb), .s_wvalid_in(wvalid), .s_wready_out(wready),
    .s_bresp_out(bresp), .s_bvalid_out(bvalid), .s_bready_in(bready),
    .s_araddr_in(araddr), .s_arvalid_in(arvalid), .s_arready_out(arready),
    .s_rdata_out(rdata), .s_rresp_out(rresp), .s_rvalid_out(rvalid), .s_rready_in(rready),
    .slow_clk_in(scl), .core_debug_in(dbg), .sys_idle_in(idle),
    .fault_irq_out(irq), .wdt_fault_out(fault),
    .core_reset_req_out(creq), .full_reset_req_out(freq)
  );
  wwd_sys_model sys (
    .sys_clk_in(clk), .core_req_in(creq), .full_req_in(freq),
    .slow_clk_out(scl), .rst_n_out(crst)
  );

  // 100 mhz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one write: address and data offered together, each dropped once taken
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    logic aw_p, w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (aw_p && awready) begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_p && wready) begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask

  // one read, data taken at the edge that sees rvalid
  task automatic axr(input logic [3:0] a);
    logic ar_p;
    ar_p = 1'b1;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (ar_p && arready) begin
        ar_p = 1'b0;
        arvalid <= 1'b0;
      end
    end while (!rvalid);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // config write; the model keeps only the first after reset
  task automatic cfgw(input logic [31:0] d);
    axw(CFG_OFS, d);
    // only enabled byte lanes land, and only on the first write
    for (int i = 0; i < 4; i++) begin
      if (!m_lock && wstrb[i]) m_cfg[i*8 +: 8] = d[i*8 +: 8];
    end
    m_cfg = m_cfg & CFG_WMASK;
    m_lock = 1'b1;
  endtask

  task automatic do_reset();
    rstb <= 1'b0;
    repeat (4) @(posedge clk);
    rstb <= 1'b1;
    m_cfg = CFG_RESET;
    m_lock = 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [31:0] mk(logic [11:0] ld, logic [11:0] dl, logic fi, logic re, logic co, logic di);
    return {4'h0, dl, di, co, re, fi, ld};
  endfunction

  // main sequence
  initial begin
    seed = 32'h6dbe927d;
    error_cnt = 0;
    checks = 0;
    {awvalid, wvalid, bready, arvalid, rready, dbg, idle} = 7'h00;
    {awaddr, araddr, wdata} = 40'h0;
    wstrb = 4'hf;
    do_reset();
    axr(CFG_OFS);
    chk("cfg reset", v, m_cfg);
    chk("cfg read resp", 32'(resp), 32'(RESP_OKAY));
    axr(FLAGS_OFS);
    chk("flags reset", v, 32'h0);
    axr(4'hc);
    chk("unmapped resp", 32'(resp), 32'(RESP_SLVERR));
    axw(4'hc, 32'h0);
    chk("unmapped write resp", 32'(resp), 32'(RESP_SLVERR));
    axw(CMD_OFS, 32'ha5000001);
    axr(FLAGS_OFS);
    chk("full range restart", v, 32'h0);
    $display("test reset values done");
    // locked config, bad key, early restart
    cfgw(mk(12'h002, 12'h001, 1, 0, 0, 0));
    cfgw($random(seed));
    axr(CFG_OFS);
    chk("cfg locked", v, m_cfg);
    v = $random(seed);
    v[0] = 1'b1;
    if (v[31:24] == CMD_KEY) v[31:24] = 8'h5a;
    axw(CMD_OFS, v);
    axr(FLAGS_OFS);
    chk("bad key", v, 32'h0);
    axw(CMD_OFS, 32'ha5000001);
    chk("err irq", 32'(irq), 32'h1);
    chk("err fault", 32'(fault), 32'h1);
    chk("no req", 32'({creq, freq}), 32'h0);
    axr(FLAGS_OFS);
    chk("err flag", v, 32'h2);
    axr(FLAGS_OFS);
    chk("flags cleared", v, 32'h0);
    chk("irq cleared", 32'(irq), 32'h0);
    $display("test window error done");
    // in-window restart, then time the next underflow with halts off
    repeat (700) @(posedge clk);
    axw(CMD_OFS, 32'ha5000001);
    for (n = 0; n < 2000 && irq !== 1'b1; n++) begin
      @(posedge clk);
      dbg <= 1'($random(seed));
      idle <= 1'($random(seed));
    end
    chk("underflow time", 32'(n > 1500 && n < 1560), 32'h1);
    chk("unf no fault", 32'(fault), 32'h0);
    axr(FLAGS_OFS);
    chk("unf flag", v, 32'h1);
    $display("test underflow done");
    // fault reset of either scope through the reset controller
    for (int s = 0; s < 2; s++) begin
      do_reset();
      cfgw(mk(12'h001, 12'h000, 1, 1, s[0], 0));
      axw(CMD_OFS, 32'ha5000001);
      chk("core req", 32'(creq), 32'(s));
      chk("full req", 32'(freq), 32'(1 - s));
      for (n = 0; n < 20 && crst !== 1'b0; n++) @(posedge clk);
      chk("fault reset pulse", 32'(n < 20), 32'h1);
      repeat (6) @(posedge clk);
      m_cfg = CFG_RESET;
      m_lock = 1'b0;
      axr(FLAGS_OFS);
      chk("flags after fault reset", v, 32'h0);
      axr(CFG_OFS);
      chk("cfg after fault reset", v, m_cfg);
    end
    $display("test fault reset done");
    // disabled timer still catches early restarts
    cfgw(mk(12'h003, 12'h000, 0, 0, 0, 1));
    repeat (2200) @(posedge clk);
    axr(FLAGS_OFS);
    chk("disabled no underflow", v, 32'h0);
    axw(CMD_OFS, 32'ha5000001);
    chk("irq masked", 32'(irq), 32'h0);
    axr(FLAGS_OFS);
    chk("disabled restart error", v, 32'h2);
    $display("test disabled done");
    // halts: low lanes only, so reset halt bits and full window stay
    do_reset();
    wstrb <= 4'h3;
    cfgw(32'h00001001);
    wstrb <= 4'hf;
    dbg <= 1'b1;
    repeat (1500) @(posedge clk);
    chk("debug halt", 32'(irq), 32'h0);
    dbg <= 1'b0;
    idle <= 1'b1;
    repeat (1500) @(posedge clk);
    chk("idle halt", 32'(irq), 32'h0);
    idle <= 1'b0;
    for (n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge clk);
    chk("resume time", 32'(n > 1000 && n < 1040), 32'h1);
    axr(CFG_OFS);
    chk("lane merge", v, m_cfg);
    $display("test halts done");
    finish_test();
  end

  // hang guard, well past the expected run length
  initial begin
    #200000;
    error_cnt++;
    $display("timeout");
    finish_test();
  end
endmodule // windowed_watchdog_timer_tb_top
